// file: design/hpb_pkg.sv
package hpb_pkg;

	// Data bus and display geometry
	localparam int DATA_W = 8;
	localparam int COL_COUNT = 132;
	localparam int ROW_COUNT = 64;

	// Write FIFO shape: command/data flag above the byte
	localparam int FIFO_W = DATA_W + 1;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_DC_BIT = DATA_W;

	// Strap codes, strap bit 0 in code bit 0
	localparam logic [2:0] STRAP_SERIAL = 3'h0;
	localparam logic [2:0] STRAP_TWO_WIRE = 3'h2;
	localparam logic [2:0] STRAP_ENABLE = 3'h4;
	localparam logic [2:0] STRAP_SPLIT = 3'h6;

	// Data line roles in serial and two-wire modes
	localparam int SCLK_BIT = 0;
	localparam int SERIAL_DATA_IN_BIT = 1;

	// Reset values
	localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [2:0] STRAP_RESET = 3'h0;

	typedef enum logic [2:0]
	{
		MODE_SERIAL,
		MODE_TWO_WIRE,
		MODE_ENABLE,
		MODE_SPLIT,
		MODE_INVALID
	} hpb_mode_e;

endpackage

// file: design/hpb_stream_if.sv
`timescale 1ns/1ps

interface hpb_stream_if #(parameter int WIDTH = 9);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport src
	(
		output valid,
		output data,
		input ready
	);

	modport snk
	(
		input valid,
		input data,
		output ready
	);
endinterface

// file: design/hpb_fifo.sv
`timescale 1ns/1ps

module hpb_fifo
	import hpb_pkg::*;
#(
	parameter int WIDTH = FIFO_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clear,
	// Streams
	hpb_stream_if.snk s_in,
	hpb_stream_if.src s_out
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;

	wire full = (count_q == CNT_FULL);
	wire empty = (count_q == '0);
	wire push = s_in.valid & ~full;
	wire pop = s_out.ready & ~empty;
	wire [AW-1:0] wr_ptr_nx = (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
	wire [AW-1:0] rd_ptr_nx = (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;

	assign s_in.ready = ~full;
	assign s_out.valid = ~empty;
	assign s_out.data = mem_q[rd_ptr_q];

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= s_in.data;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else if (i_clear)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_nx;
			if (pop)
				rd_ptr_q <= rd_ptr_nx;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end

endmodule

// file: design/hpb_host_port.sv
// Summary of operation
// [R1] Straps pick mode: 000 serial, 010 two-wire, 100 enable-strobe, 110 split-strobe.
// [R2] Init pin low runs full initialisation; host keeps it high normally.
// [R3] Transfers only accepted while chip select is low; strobes ignored otherwise.
// [R4] Data/command high sends byte to display memory, low to command register.
// [R5] Reads return status with data/command low, display memory with it high.
// [R6] Enable-strobe mode: direction low means write, high means read.
// [R7] Enable-strobe transfer active while enable high; data latched on enable fall.
// [R8] Host performs one dummy read before first display-data read.
// [R9] Split-strobe: drive read data while read strobe low; its rise ends read.
// [R10] Split-strobe: byte captured on write strobe rise, read strobe high.
// [R11] Static strobe form: chip select rise completes the selected read or write.
// [R12] Serial mode: line 0 is serial clock, line 1 serial data.
// [R13] Two-wire mode: line 0 clock, data/command pin is the low address bit.
// [R14] Column and row drivers float whenever the display is off.
// [R15] A frame timing output lets the host avoid tearing.
// [R16] Clock source pin high selects internal oscillator, low the external clock.
// [R17] Data lines driven only during an active selected read cycle.
`timescale 1ns/1ps

module hpb_host_port
	import hpb_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_init_pin_n,
	// Straps and clock source
	input wire logic [2:0] i_bus_mode_straps,
	input wire logic i_int_osc_select,
	input wire logic i_ext_osc_input,
	// Host bus
	input wire logic i_cs_n,
	input wire logic i_dc,
	input wire logic i_strobe,
	input wire logic i_rw,
	input wire logic [DATA_W-1:0] i_d,
	output logic [DATA_W-1:0] o_d,
	output logic o_d_oe,
	// Core side: status and display memory read
	input wire logic [DATA_W-1:0] i_status,
	input wire logic [DATA_W-1:0] i_mem_rd_data,
	output logic o_mem_rd_req,
	// Core side: write stream
	output logic o_wr_valid,
	output logic [DATA_W-1:0] o_wr_data,
	output logic o_wr_is_data,
	input wire logic i_wr_ready,
	output logic o_busy,
	output logic o_overrun,
	// Mode and serial line taps
	output hpb_mode_e o_mode,
	output logic o_init_active,
	output logic o_serial_clk,
	output logic o_serial_data,
	output logic o_slave_addr_lsb,
	// Clock source
	output logic o_int_osc_en,
	output logic o_ext_osc_sample,
	// Panel drivers and frame sync
	input wire logic i_display_on,
	input wire logic i_frame_sync,
	input wire logic [COL_COUNT-1:0] i_column_level,
	input wire logic [ROW_COUNT-1:0] i_row_level,
	output logic [COL_COUNT-1:0] o_column_drive_out,
	output logic [COL_COUNT-1:0] o_column_drive_oe,
	output logic [ROW_COUNT-1:0] o_row_drive_out,
	output logic [ROW_COUNT-1:0] o_row_drive_oe,
	output logic o_tear_sync_out
);

	////////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rst_meta_q;
	logic rst_sync_q;
	wire rst_n = rst_sync_q;

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Initialisation and strap capture

	logic init_q;
	logic [2:0] strap_q;
	hpb_mode_e mode_q;
	hpb_mode_e mode_d;

	always_comb
	begin
		case (strap_q)
			STRAP_SERIAL: mode_d = MODE_SERIAL; // [R1]
			STRAP_TWO_WIRE: mode_d = MODE_TWO_WIRE; // [R1]
			STRAP_ENABLE: mode_d = MODE_ENABLE; // [R1]
			STRAP_SPLIT: mode_d = MODE_SPLIT; // [R1]
			default: mode_d = MODE_INVALID;
		endcase
	end

	// Straps are re-read while initialisation runs and on first cycle after reset
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			init_q <= 1'b1;
			strap_q <= STRAP_RESET;
			mode_q <= MODE_INVALID;
		end
		else
		begin
			init_q <= ~i_init_pin_n; // [R2]
			if (init_q)
				strap_q <= i_bus_mode_straps; // [R1]
			mode_q <= mode_d;
		end
	end

	wire run = ~init_q; // [R2]
	wire mode_en = run & (mode_q == MODE_ENABLE);
	wire mode_sp = run & (mode_q == MODE_SPLIT);

	////////////////////////////////////////////////////////////////////////////
	// Bus sampling

	logic cs_n_q;
	logic dc_q;
	logic strobe_q;
	logic rw_q;
	logic [DATA_W-1:0] d_q;

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_n_q <= 1'b1;
			dc_q <= 1'b0;
			strobe_q <= 1'b0;
			rw_q <= 1'b0;
			d_q <= BYTE_RESET;
		end
		else
		begin
			cs_n_q <= i_cs_n;
			dc_q <= i_dc;
			strobe_q <= i_strobe;
			rw_q <= i_rw;
			d_q <= i_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transfer decode

	// Enable-strobe: falling enable while selected ends the cycle
	wire en_fall = strobe_q & ~i_strobe & ~cs_n_q; // [R3] [R7]
	wire en_wr = mode_en & en_fall & ~rw_q; // [R6] [R7]
	wire en_rd = mode_en & en_fall & rw_q; // [R6]
	wire en_rd_act = mode_en & i_strobe & ~i_cs_n & i_rw; // [R6] [R7]

	// Split-strobe: strobe input is the read strobe, direction input the write strobe
	wire wr_rise = ~rw_q & i_rw & ~cs_n_q & strobe_q; // [R10]
	wire rd_rise = ~strobe_q & i_strobe & ~cs_n_q & rw_q; // [R9]
	wire cs_rise = ~cs_n_q & i_cs_n;
	wire st_wr = cs_rise & ~rw_q & ~i_rw & strobe_q & i_strobe; // [R11]
	wire st_rd = cs_rise & ~strobe_q & ~i_strobe & rw_q & i_rw; // [R11]
	wire sp_wr = mode_sp & (wr_rise | st_wr); // [R3] [R10] [R11]
	wire sp_rd = mode_sp & (rd_rise | st_rd); // [R9] [R11]
	wire sp_rd_act = mode_sp & ~i_strobe & ~i_cs_n & i_rw; // [R9]

	wire wr_evt = en_wr | sp_wr;
	wire rd_evt = en_rd | sp_rd;
	wire rd_act = en_rd_act | sp_rd_act; // [R3]

	////////////////////////////////////////////////////////////////////////////
	// Read path

	logic [DATA_W-1:0] mem_buf_q;
	logic [DATA_W-1:0] rd_out_q;
	logic mem_rd_req_q;

	// Display-data reads return the previously fetched byte, so the first is a dummy
	wire data_rd_done = rd_evt & dc_q; // [R8]
	wire [DATA_W-1:0] rd_sel = i_dc ? mem_buf_q : i_status; // [R5]

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_buf_q <= BYTE_RESET;
			rd_out_q <= BYTE_RESET;
			mem_rd_req_q <= 1'b0;
		end
		else
		begin
			if (init_q)
				mem_buf_q <= BYTE_RESET; // [R2]
			else if (data_rd_done)
				mem_buf_q <= i_mem_rd_data; // [R8]
			rd_out_q <= rd_sel; // [R5]
			mem_rd_req_q <= data_rd_done;
		end
	end

	assign o_d = rd_out_q;
	assign o_d_oe = rd_act; // [R17]
	assign o_mem_rd_req = mem_rd_req_q;

	////////////////////////////////////////////////////////////////////////////
	// Write path

	hpb_stream_if #(.WIDTH(FIFO_W)) wr_in_if ();
	hpb_stream_if #(.WIDTH(FIFO_W)) wr_out_if ();

	logic overrun_q;

	assign wr_in_if.valid = wr_evt;
	assign wr_in_if.data = {dc_q, d_q}; // [R4]
	assign wr_out_if.ready = i_wr_ready;

	hpb_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo
	(
		.i_clk(i_mclk),
		.i_rst_n(rst_n),
		.i_clear(init_q),
		.s_in(wr_in_if),
		.s_out(wr_out_if)
	);

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			overrun_q <= 1'b0;
		else
			overrun_q <= wr_evt & ~wr_in_if.ready;
	end

	assign o_wr_valid = wr_out_if.valid;
	assign o_wr_data = wr_out_if.data[DATA_W-1:0];
	assign o_wr_is_data = wr_out_if.data[FIFO_DC_BIT]; // [R4]
	assign o_busy = ~wr_in_if.ready;
	assign o_overrun = overrun_q;

	////////////////////////////////////////////////////////////////////////////
	// Serial taps, clock source, panel drivers

	logic ser_clk_q;
	logic ser_data_q;
	logic sa_lsb_q;
	logic osc_en_q;
	logic ext_osc_q;
	logic tear_q;
	logic disp_on_q;
	logic [COL_COUNT-1:0] col_q;
	logic [ROW_COUNT-1:0] row_q;

	wire ser_mode = run & ((mode_q == MODE_SERIAL) | (mode_q == MODE_TWO_WIRE));

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ser_clk_q <= 1'b0;
			ser_data_q <= 1'b0;
			sa_lsb_q <= 1'b0;
			osc_en_q <= 1'b0;
			ext_osc_q <= 1'b0;
			tear_q <= 1'b0;
			disp_on_q <= 1'b0;
			col_q <= '0;
			row_q <= '0;
		end
		else
		begin
			ser_clk_q <= ser_mode & i_d[SCLK_BIT]; // [R12] [R13]
			ser_data_q <= ser_mode & i_d[SERIAL_DATA_IN_BIT]; // [R12] [R13]
			sa_lsb_q <= run & (mode_q == MODE_TWO_WIRE) & i_dc; // [R13]
			osc_en_q <= i_int_osc_select; // [R16]
			ext_osc_q <= ~i_int_osc_select & i_ext_osc_input; // [R16]
			tear_q <= run & i_frame_sync; // [R15]
			disp_on_q <= run & i_display_on; // [R14]
			col_q <= i_column_level;
			row_q <= i_row_level;
		end
	end

	assign o_mode = mode_q;
	assign o_init_active = init_q;
	assign o_serial_clk = ser_clk_q;
	assign o_serial_data = ser_data_q;
	assign o_slave_addr_lsb = sa_lsb_q;
	assign o_int_osc_en = osc_en_q;
	assign o_ext_osc_sample = ext_osc_q;
	assign o_tear_sync_out = tear_q;
	assign o_column_drive_out = col_q;
	assign o_row_drive_out = row_q;
	assign o_column_drive_oe = {COL_COUNT{disp_on_q}}; // [R14]
	assign o_row_drive_oe = {ROW_COUNT{disp_on_q}}; // [R14]

endmodule

// file: tb/hpb_props.sv
`timescale 1ns/1ps

module hpb_props
	import hpb_pkg::*;
(
	// Host bus
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic i_dc,
	input wire logic i_strobe,
	input wire logic i_rw,
	input wire logic [DATA_W-1:0] i_d,
	input wire logic [DATA_W-1:0] i_status,
	input wire logic [DATA_W-1:0] o_d,
	input wire logic o_d_oe,
	// Core and panel side
	input wire logic i_display_on,
	input wire logic i_frame_sync,
	input wire logic o_mem_rd_req,
	input wire logic o_wr_valid,
	input wire logic [DATA_W-1:0] o_wr_data,
	input wire logic o_wr_is_data,
	input hpb_mode_e o_mode,
	input wire logic o_init_active,
	input wire logic [COL_COUNT-1:0] o_column_drive_oe,
	input wire logic [ROW_COUNT-1:0] o_row_drive_oe,
	input wire logic o_tear_sync_out
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	wire en_ok = o_mode == MODE_ENABLE && !o_init_active;
	wire sp_ok = o_mode == MODE_SPLIT && !o_init_active;

	sequence en_wr;
		en_ok && $past(i_strobe) && !i_strobe && !$past(i_cs_n) && !$past(i_rw);
	endsequence
	sequence sp_wr;
		sp_ok && !$past(i_cs_n) && $past(i_strobe) && !$past(i_rw) && i_rw;
	endsequence
	sequence cs_wr;
		sp_ok && !$past(i_cs_n) && i_cs_n && $past(i_strobe) && i_strobe && !$past(i_rw) && !i_rw;
	endsequence
	// Byte and kind come from the sample before the latching edge
	property lands(ev);
		ev ##0 !o_wr_valid |=> o_wr_valid && o_wr_data == $past(i_d, 2)
			&& o_wr_is_data == $past(i_dc, 2);
	endproperty

	a_enable_write_lands: assert property (lands(en_wr))
		else $error("enable write not queued");
	a_split_write_lands: assert property (lands(sp_wr))
		else $error("split write not queued");
	a_cs_latch_lands: assert property (lands(cs_wr))
		else $error("select rise write not queued");
	a_deselect_quiet: assert property
		($past(i_cs_n) && i_cs_n && !o_wr_valid |=> !o_wr_valid)
		else $error("write taken while deselected");
	a_oe_read_only: assert property
		(o_d_oe |-> !i_cs_n && i_rw && (o_mode == MODE_ENABLE ? i_strobe : !i_strobe))
		else $error("data lines driven outside a read");
	a_status_read: assert property
		($past(o_d_oe) && o_d_oe && !$past(i_dc) |-> o_d == $past(i_status))
		else $error("status byte not returned");
	a_mem_fetch: assert property
		(sp_ok && $rose(i_strobe) && !$past(i_cs_n) && $past(i_rw) && i_dc && $past(i_dc)
			|=> o_mem_rd_req)
		else $error("data read did not fetch memory");
	a_panel_float: assert property
		(!$past(i_display_on) |-> o_column_drive_oe == '0 && o_row_drive_oe == '0)
		else $error("panel drivers on while display off");
	a_tear_follow: assert property
		(!$past(o_init_active) && !o_init_active |-> o_tear_sync_out == $past(i_frame_sync))
		else $error("frame sync output wrong");
endmodule

bind hpb_host_port hpb_props u_props
(
	.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_dc(i_dc), .i_strobe(i_strobe),
	.i_rw(i_rw), .i_d(i_d), .i_status(i_status), .o_d(o_d), .o_d_oe(o_d_oe),
	.i_display_on(i_display_on), .i_frame_sync(i_frame_sync), .o_mem_rd_req(o_mem_rd_req),
	.o_wr_valid(o_wr_valid), .o_wr_data(o_wr_data), .o_wr_is_data(o_wr_is_data),
	.o_mode(o_mode), .o_init_active(o_init_active), .o_column_drive_oe(o_column_drive_oe),
	.o_row_drive_oe(o_row_drive_oe), .o_tear_sync_out(o_tear_sync_out)
);

// file: tb/hpb_host_model.sv
`timescale 1ns/1ps

module hpb_host_model
	import hpb_pkg::*;
(
	// Clock and device answer
	input wire logic i_clk,
	input wire logic [DATA_W-1:0] i_d,
	input wire logic i_d_oe,
	input wire logic i_ghost,
	// Host bus
	output logic o_cs_n,
	output logic o_dc,
	output logic o_strobe,
	output logic o_rw,
	output logic [DATA_W-1:0] o_bus
);
	logic [DATA_W-1:0] dv = 8'h00;
	logic drv = 1'b0;

	// Released lines show the inverse of the last byte
	assign o_bus = i_d_oe ? i_d : (drv ? dv : ~dv);

	initial
	begin
		o_cs_n = 1'b1;
		o_dc = 1'b0;
		o_strobe = 1'b0;
		o_rw = 1'b0;
	end

	// Serial modes: host drives the data lines, enable and direction tied low
	task park(input logic [DATA_W-1:0] v);
		o_strobe <= 1'b0;
		o_rw <= 1'b0;
		dv <= v;
		drv <= 1'b1;
	endtask

	// One transfer: enable strobe (sp=0), split strobes (sp=1), static form (f2=1)
	task xfer(input logic sp, f2, rd, dcv, input logic [DATA_W-1:0] v,
		output logic [DATA_W-1:0] q);
		o_cs_n <= i_ghost;
		o_dc <= dcv;
		dv <= v;
		drv <= !rd;
		o_rw <= rd;
		o_strobe <= sp ? !rd : 1'b1;
		repeat (2) @(posedge i_clk);
		q = i_d;
		if (!sp)
			o_strobe <= 1'b0;
		else if (f2)
			o_cs_n <= 1'b1;
		else
		begin
			o_strobe <= 1'b1;
			o_rw <= 1'b1;
		end
		@(posedge i_clk);
		o_cs_n <= 1'b1;
		o_strobe <= sp;
		o_rw <= sp;
		drv <= 1'b0;
		@(posedge i_clk);
	endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps

`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
	$display("FAIL %s expected %h seen %h", n, e, a); end end

module testbench
	import hpb_pkg::*;
;
	logic i_mclk = 1'b0, i_rst_n = 1'b0, i_init_pin_n = 1'b0, i_int_osc_select = 1'b1;
	logic i_ext_osc_input = 1'b0, i_wr_ready = 1'b0, i_display_on = 1'b0, i_frame_sync = 1'b0;
	logic [2:0] i_bus_mode_straps = STRAP_RESET;
	logic [DATA_W-1:0] i_status = 8'h5A, i_mem_rd_data = 8'hC3, i_d, o_d, o_wr_data, q;
	logic [COL_COUNT-1:0] i_column_level = {33{4'h9}}, o_column_drive_out, o_column_drive_oe;
	logic [ROW_COUNT-1:0] i_row_level = {16{4'h6}}, o_row_drive_out, o_row_drive_oe;
	logic i_cs_n, i_dc, i_strobe, i_rw, o_d_oe, o_mem_rd_req, o_wr_valid, o_wr_is_data, o_busy;
	logic o_overrun, o_init_active, o_serial_clk, o_serial_data, o_slave_addr_lsb, o_int_osc_en;
	logic o_ext_osc_sample, o_tear_sync_out, ghost = 1'b0, ovr = 1'b0;
	hpb_mode_e o_mode;
	int mismatches = 0, samples_checked = 0, cycles = 0;

	hpb_host_port DUT
	(
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_init_pin_n(i_init_pin_n),
		.i_bus_mode_straps(i_bus_mode_straps), .i_int_osc_select(i_int_osc_select),
		.i_ext_osc_input(i_ext_osc_input), .i_cs_n(i_cs_n), .i_dc(i_dc), .i_strobe(i_strobe),
		.i_rw(i_rw), .i_d(i_d), .o_d(o_d), .o_d_oe(o_d_oe), .i_status(i_status),
		.i_mem_rd_data(i_mem_rd_data), .o_mem_rd_req(o_mem_rd_req), .o_wr_valid(o_wr_valid),
		.o_wr_data(o_wr_data), .o_wr_is_data(o_wr_is_data), .i_wr_ready(i_wr_ready),
		.o_busy(o_busy), .o_overrun(o_overrun), .o_mode(o_mode), .o_init_active(o_init_active),
		.o_serial_clk(o_serial_clk), .o_serial_data(o_serial_data),
		.o_slave_addr_lsb(o_slave_addr_lsb), .o_int_osc_en(o_int_osc_en),
		.o_ext_osc_sample(o_ext_osc_sample), .i_display_on(i_display_on),
		.i_frame_sync(i_frame_sync), .i_column_level(i_column_level), .i_row_level(i_row_level),
		.o_column_drive_out(o_column_drive_out), .o_column_drive_oe(o_column_drive_oe),
		.o_row_drive_out(o_row_drive_out), .o_row_drive_oe(o_row_drive_oe),
		.o_tear_sync_out(o_tear_sync_out)
	);
	hpb_host_model host (.i_clk(i_mclk), .i_d(o_d), .i_d_oe(o_d_oe), .i_ghost(ghost),
		.o_cs_n(i_cs_n), .o_dc(i_dc), .o_strobe(i_strobe), .o_rw(i_rw), .o_bus(i_d));

	initial forever #10 i_mclk = ~i_mclk;

	// Frame sync stimulus, overrun capture and hang guard
	always @(posedge i_mclk)
	begin
		cycles <= cycles + 1;
		i_frame_sync <= cycles[2];
		if (o_overrun)
			ovr <= 1'b1;
		if (cycles == 5000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end

	task tally_and_finish;
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task boot(input logic [2:0] s, input hpb_mode_e m);
		i_init_pin_n <= 1'b0;
		i_bus_mode_straps <= s;
		repeat (4) @(posedge i_mclk);
		`CHK("init", 1'b1, o_init_active)
		i_init_pin_n <= 1'b1;
		repeat (6) @(posedge i_mclk);
		`CHK("mode", m, o_mode)
	endtask

	task pop(input logic d, input logic [DATA_W-1:0] v);
		`CHK("valid", 1'b1, o_wr_valid)
		`CHK("kind", d, o_wr_is_data)
		`CHK("byte", v, o_wr_data)
		i_wr_ready <= 1'b1;
		@(posedge i_mclk);
		i_wr_ready <= 1'b0;
		@(posedge i_mclk);
	endtask

	task t_enable;
		boot(STRAP_ENABLE, MODE_ENABLE);
		host.xfer(0, 0, 1, 1, 8'h00, q);
		`CHK("dummy", BYTE_RESET, q)
		host.xfer(0, 0, 1, 0, 8'h00, q);
		`CHK("status", i_status, q)
		host.xfer(0, 0, 1, 1, 8'h00, q);
		`CHK("mem", i_mem_rd_data, q)
		`CHK("oe idle", 1'b0, o_d_oe)
		ghost <= 1'b1;
		@(posedge i_mclk);
		host.xfer(0, 0, 0, 1, 8'hEE, q);
		ghost <= 1'b0;
		@(posedge i_mclk);
		`CHK("deselect", 1'b0, o_wr_valid)
		for (int k = 0; k < 9; k++)
			host.xfer(0, 0, 0, k[0], 8'h10 + k[7:0], q);
		`CHK("full", 1'b1, o_busy)
		@(posedge i_mclk);
		`CHK("overrun", 1'b1, ovr)
		for (int k = 0; k < 8; k++)
			pop(k[0], 8'h10 + k[7:0]);
		`CHK("empty", 1'b0, o_wr_valid)
	endtask

	task t_split;
		boot(STRAP_SPLIT, MODE_SPLIT);
		host.xfer(1, 0, 1, 1, 8'h00, q);
		`CHK("dummy", BYTE_RESET, q)
		host.xfer(1, 1, 1, 0, 8'h00, q);
		`CHK("status", i_status, q)
		host.xfer(1, 1, 1, 1, 8'h00, q);
		`CHK("mem", i_mem_rd_data, q)
		host.xfer(1, 0, 0, 0, 8'h81, q);
		pop(1'b0, 8'h81);
		host.xfer(1, 1, 0, 1, 8'h7E, q);
		pop(1'b1, 8'h7E);
	endtask

	task t_misc;
		host.park(8'h02);
		boot(STRAP_SERIAL, MODE_SERIAL);
		`CHK("sclk", 1'b0, o_serial_clk)
		`CHK("serial_data_in", 1'b1, o_serial_data)
		host.park(8'h01);
		boot(STRAP_TWO_WIRE, MODE_TWO_WIRE);
		`CHK("addr", i_dc, o_slave_addr_lsb)
		`CHK("scl", 1'b1, o_serial_clk)
		`CHK("sda", 1'b0, o_serial_data)
		boot(3'h7, MODE_INVALID);
		`CHK("panel off", 1'b0, |{o_column_drive_oe, o_row_drive_oe})
		i_display_on <= 1'b1;
		i_int_osc_select <= 1'b0;
		i_ext_osc_input <= 1'b1;
		repeat (3) @(posedge i_mclk);
		`CHK("panel on", '1, o_column_drive_oe)
		`CHK("levels", i_column_level, o_column_drive_out)
		`CHK("rows on", '1, o_row_drive_oe)
		`CHK("row levels", i_row_level, o_row_drive_out)
		`CHK("osc", 2'h1, {o_int_osc_en, o_ext_osc_sample})
	endtask

	initial
	begin
		repeat (5) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_enable;
		t_split;
		t_misc;
		tally_and_finish;
	end
endmodule
